// ==== hdl/rcs_defines.svh ====
// Constants for the serializer reference-clock and self-test select block.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef RCS_DEFINES_SVH
`define RCS_DEFINES_SVH

// ==========================================================================
// Register offsets and reset values
// ==========================================================================
`define RCS_REG_CLK_SRC 8'h03
`define RCS_REG_OSC_SEL 8'h14
`define RCS_CLK_SRC_RST 8'h00
`define RCS_OSC_SEL_RST 8'h00
`define RCS_RDATA_ZERO 8'h00

// ==========================================================================
// Field positions
// ==========================================================================
`define RCS_BIT_PCLK_DIS 1
`define RCS_OSC_MSB 2
`define RCS_OSC_LSB 1
`define RCS_GPO_TWO 2
`define RCS_GPO_THREE 3

// ==========================================================================
// Field codes and strap level
// ==========================================================================
`define RCS_OSC_CODE_HI 2'h1
`define RCS_OSC_CODE_LOW 2'h3
`define RCS_STRAP_OSC_LVL 1'b0

// ==========================================================================
// Frame clock rates, in units of 0.5 MHz
// ==========================================================================
`define RCS_F_100M 8'hc8
`define RCS_F_75M 8'h96
`define RCS_F_50M 8'h64
`define RCS_F_37M5 8'h4b
`define RCS_F_25M 8'h32
`define RCS_F_NONE 8'h00

// ==========================================================================
// Timing
// ==========================================================================
`define RCS_CLK_NS 40
`define RCS_PCLK_LOSS_NS 400
`define RCS_PCLK_LOSS_CYC (`RCS_PCLK_LOSS_NS / `RCS_CLK_NS)
`define RCS_LOSS_W 4
`define RCS_STRAP_WAIT 2'h3

`endif

// ==== hdl/rcs_pkg.sv ====
// Types shared by the reference-clock select block and its bench.
// Assumes nothing of its surroundings.
package rcs_pkg;

    // ======================================================================
    // Types
    // ======================================================================
    // Link clock source state, one-hot.
    typedef enum logic [1:0] {
        RCS_SRC_INT = 2'b01,
        RCS_SRC_PCLK = 2'b10
    } rcs_src_e;

    // Payload mode, one-hot.
    typedef enum logic [2:0] {
        RCS_PAY_10 = 3'b001,
        RCS_PAY_12H = 3'b010,
        RCS_PAY_12L = 3'b100
    } rcs_payload_e;

    // Register byte.
    typedef logic [7:0] rcs_byte_t;

endpackage

// ==== hdl/rcs_sync.sv ====
// Two-flop synchroniser for pin inputs, frozen by the clock enable.
// Assumes one core clock and an asynchronous active-high reset.
`timescale 1ns/10ps

// ==========================================================================
// Synchroniser
// ==========================================================================
module rcs_sync #(
    parameter int W = 1
) (
    input wire logic core_clk_i, // Core clock.
    input wire logic rst_i, // Asynchronous reset.
    input wire logic ce_i, // Clock enable.
    input wire logic [W-1:0] async_i, // Pin levels.
    output logic [W-1:0] sync_o // Synchronised levels.
);
    logic [W-1:0] meta; // First stage, read only by the second.

    // Two stages; the first is never read by other logic.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta <= '0;
            sync_o <= '0;
        end else if (ce_i) begin
            meta <= async_i;
            sync_o <= meta;
        end
    end
endmodule

// ==== hdl/rcs_refclk_ctrl.sv ====
// Reference-clock source selection and self-test oscillator loading.
// Assumes register accesses from the local control port, back-channel
// signals on the core clock, and raw pins that still need synchronising.
`timescale 1ns/10ps
`include "rcs_defines.svh"

// ==========================================================================
// Reference-clock select top
// ==========================================================================
// What this block does
// - Oscillator mode halves external oscillator for imager
// - Line three takes oscillator, line two drives out
// - Pixel clock edge with bit clear switches source
// - Lost pixel clock falls back to internal oscillator
// - Oscillator mode blocks remote lines two, three
// - Pixel clock mode keeps all four lines
// - Strap decode: 100k pixel, 4.7k oscillator
// - No pixel clock: link runs from internal oscillator
// - Oscillator select field sets internal frame clock
// - Self test loads select field from far end
module rcs_refclk_ctrl (
    input wire logic core_clk_i, // Core clock, 25 MHz.
    input wire logic rst_i, // Asynchronous reset, active high.
    input wire logic ce_i, // Clock enable; low freezes all state.
    input wire logic mode_strap_i, // Mode strap comparator level (pin).
    input wire logic pclk_i, // Imager pixel clock (pin).
    input wire logic gen_out_three_i, // External oscillator input (pin).
    input wire rcs_pkg::rcs_payload_e payload_mode_i, // Payload mode.
    input wire logic [3:0] remote_gpo_i, // Remote general lines, back channel.
    input wire logic bist_active_i, // Self test running, back channel.
    input wire logic bist_osc_load_i, // Load strobe for the select field.
    input wire logic [1:0] bist_osc_sel_i, // Select code from the far end.
    input wire logic [7:0] reg_addr_i, // Register offset.
    input wire logic reg_wr_i, // Register write strobe.
    input wire logic reg_rd_i, // Register read strobe.
    input wire logic [7:0] reg_wdata_i, // Register write data.
    output rcs_pkg::rcs_byte_t reg_rdata_o, // Register read data.
    output logic [3:0] gen_out_o, // General output levels.
    output logic [3:0] gen_out_oe_o, // General output enables.
    output logic osc_mode_o, // External oscillator mode selected.
    output logic strap_valid_o, // Strap has been captured.
    output logic use_pclk_o, // Link runs from the pixel clock.
    output logic link_int_osc_o, // Link runs from the internal oscillator.
    output logic [7:0] frame_freq_o // Internal frame clock, 0.5 MHz units.
);
    import rcs_pkg::*;

    // ======================================================================
    // Pin synchronisation
    // ======================================================================
    logic strap_s; // Synchronised strap level.
    logic pclk_s; // Synchronised pixel clock.
    logic osc_s; // Synchronised external oscillator.

    rcs_sync #(.W(3)) u_sync (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .async_i({mode_strap_i, pclk_i, gen_out_three_i}),
        .sync_o({strap_s, pclk_s, osc_s})
    );

    // ======================================================================
    // Mode strap capture
    // ======================================================================
    logic [1:0] strap_wait; // Settling count after reset release.

    // Waits for the synchroniser to fill, then captures the strap once.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            strap_wait <= 2'h0;
            strap_valid_o <= 1'b0;
            osc_mode_o <= 1'b0;
        end else if (ce_i && !strap_valid_o) begin
            if (strap_wait == `RCS_STRAP_WAIT) begin
                strap_valid_o <= 1'b1;
                osc_mode_o <= (strap_s == `RCS_STRAP_OSC_LVL);
            end else begin
                strap_wait <= strap_wait + 2'h1;
            end
        end
    end

    // ======================================================================
    // Registers
    // ======================================================================
    rcs_byte_t clk_src_ctl; // Clock source control register.
    rcs_byte_t osc_sel; // Internal oscillator select register.

    // Clock source control: plain read/write storage.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            clk_src_ctl <= `RCS_CLK_SRC_RST;
        end else if (ce_i && reg_wr_i && reg_addr_i == `RCS_REG_CLK_SRC) begin
            clk_src_ctl <= reg_wdata_i;
        end
    end

    // Oscillator select: the far end's load wins, and during self test
    // software cannot change the frequency field.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            osc_sel <= `RCS_OSC_SEL_RST;
        end else if (ce_i) begin
            if (reg_wr_i && reg_addr_i == `RCS_REG_OSC_SEL) begin
                osc_sel <= reg_wdata_i;
                if (bist_active_i) begin
                    osc_sel[`RCS_OSC_MSB:`RCS_OSC_LSB] <= osc_sel[`RCS_OSC_MSB:`RCS_OSC_LSB];
                end
            end
            if (bist_active_i && bist_osc_load_i) begin
                osc_sel[`RCS_OSC_MSB:`RCS_OSC_LSB] <= bist_osc_sel_i;
            end
        end
    end

    // Registered read; unmapped offsets read zero.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= `RCS_RDATA_ZERO;
        end else if (ce_i && reg_rd_i) begin
            case (reg_addr_i)
                `RCS_REG_CLK_SRC: begin
                    reg_rdata_o <= clk_src_ctl;
                end
                `RCS_REG_OSC_SEL: begin
                    reg_rdata_o <= osc_sel;
                end
                default: begin
                    reg_rdata_o <= `RCS_RDATA_ZERO;
                end
            endcase
        end
    end

    // ======================================================================
    // Internal frame clock rate
    // ======================================================================
    logic [1:0] osc_code; // Current select field.

    assign osc_code = osc_sel[`RCS_OSC_MSB:`RCS_OSC_LSB];

    // Looks up the frame clock for the select code and payload mode.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            frame_freq_o <= `RCS_F_NONE;
        end else if (ce_i) begin
            if (osc_code == `RCS_OSC_CODE_LOW) begin
                // Lowest code exists in 10-bit mode only.
                frame_freq_o <= (payload_mode_i == RCS_PAY_10) ? `RCS_F_25M : `RCS_F_NONE;
            end else if (osc_code == `RCS_OSC_CODE_HI) begin
                case (payload_mode_i)
                    RCS_PAY_10: begin
                        frame_freq_o <= `RCS_F_100M;
                    end
                    RCS_PAY_12H: begin
                        frame_freq_o <= `RCS_F_75M;
                    end
                    default: begin
                        frame_freq_o <= `RCS_F_50M;
                    end
                endcase
            end else begin
                case (payload_mode_i)
                    RCS_PAY_10: begin
                        frame_freq_o <= `RCS_F_50M;
                    end
                    RCS_PAY_12H: begin
                        frame_freq_o <= `RCS_F_37M5;
                    end
                    default: begin
                        frame_freq_o <= `RCS_F_25M;
                    end
                endcase
            end
        end
    end

    // ======================================================================
    // Pixel clock detection and source selection
    // ======================================================================
    logic pclk_q; // Previous pixel clock sample.
    logic pclk_edge; // Pixel clock changed level.
    logic [`RCS_LOSS_W-1:0] loss_cnt; // Cycles since the last edge.
    logic pclk_lost; // No edge for the loss window.
    rcs_src_e src_state; // Link clock source.
    rcs_src_e next_src_state; // Next link clock source.

    assign pclk_edge = pclk_s ^ pclk_q;
    assign pclk_lost = (loss_cnt == `RCS_LOSS_W'(`RCS_PCLK_LOSS_CYC));

    // Tracks pixel clock activity with a saturating silence counter.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pclk_q <= 1'b0;
            loss_cnt <= '0;
        end else if (ce_i) begin
            pclk_q <= pclk_s;
            if (pclk_edge) begin
                loss_cnt <= '0;
            end else if (!pclk_lost) begin
                loss_cnt <= loss_cnt + `RCS_LOSS_W'(1);
            end
        end
    end

    // Chooses the next link clock source.
    always_comb begin
        next_src_state = src_state;
        case (src_state)
            RCS_SRC_INT: begin
                if (pclk_edge && !clk_src_ctl[`RCS_BIT_PCLK_DIS]) begin
                    next_src_state = RCS_SRC_PCLK;
                end
            end
            RCS_SRC_PCLK: begin
                if (pclk_lost) begin
                    next_src_state = RCS_SRC_INT;
                end
            end
            default: begin
                next_src_state = RCS_SRC_INT;
            end
        endcase
    end

    // Holds the source; the link starts on the internal oscillator.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            src_state <= RCS_SRC_INT;
        end else if (ce_i) begin
            src_state <= next_src_state;
        end
    end

    assign use_pclk_o = (src_state == RCS_SRC_PCLK);
    assign link_int_osc_o = !use_pclk_o;

    // ======================================================================
    // Reference divider and general output routing
    // ======================================================================
    logic osc_q; // Previous oscillator sample.
    logic osc_rise; // Oscillator rising edge.
    logic div_q; // Halved oscillator.

    assign osc_rise = osc_s && !osc_q;

    // In oscillator mode, toggles on each oscillator rising edge, halving its rate.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            osc_q <= 1'b0;
            div_q <= 1'b0;
        end else if (ce_i) begin
            osc_q <= osc_s;
            if (osc_mode_o && osc_rise) begin
                div_q <= !div_q;
            end
        end
    end

    // Drives the general lines; oscillator mode takes lines two and three.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            gen_out_o <= 4'h0;
            gen_out_oe_o <= 4'h0;
        end else if (ce_i && strap_valid_o) begin
            gen_out_o <= remote_gpo_i;
            gen_out_oe_o <= 4'hf;
            if (osc_mode_o) begin
                gen_out_o[`RCS_GPO_TWO] <= div_q;
                gen_out_o[`RCS_GPO_THREE] <= 1'b0;
                gen_out_oe_o[`RCS_GPO_THREE] <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Checks
    // ======================================================================
    AST_DIV_TOGGLE: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (ce_i && osc_mode_o && osc_rise) |=> (div_q != $past(div_q)))
        else $error("Divider did not toggle on oscillator edge.");

    AST_GEN_OUT_THREE_INPUT: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (strap_valid_o && osc_mode_o && ce_i) |=> (!gen_out_oe_o[3] && gen_out_oe_o[2]
        && gen_out_o[2] == $past(div_q)))
        else $error("Oscillator mode line roles wrong.");

    AST_PCLK_SWITCH: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (ce_i && !use_pclk_o && pclk_edge && !clk_src_ctl[1]) |=> use_pclk_o)
        else $error("No switch to pixel clock after edge.");

    AST_PCLK_BLOCKED: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (!use_pclk_o && clk_src_ctl[1]) |=> !use_pclk_o)
        else $error("Switched to pixel clock while disabled.");

    AST_FALLBACK: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (use_pclk_o && ce_i && !pclk_edge && loss_cnt == 4'h9) ##1 (ce_i && !pclk_edge)
        |=> !use_pclk_o)
        else $error("No fallback after pixel clock loss.");

    AST_NO_REMOTE: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (ce_i && strap_valid_o && osc_mode_o && $stable(div_q)) |=> $stable(gen_out_o[3:2]))
        else $error("Remote lines reached lines two or three.");

    AST_GPO_PASS: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (ce_i && strap_valid_o && !osc_mode_o) |=>
        (gen_out_o == $past(remote_gpo_i) && gen_out_oe_o == 4'hf))
        else $error("General lines not passed in pixel clock mode.");

    AST_STRAP_DECODE: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (ce_i && !strap_valid_o && strap_wait == 2'h3) |=> (strap_valid_o
        && osc_mode_o == ($past(strap_s) == 1'b0)))
        else $error("Strap decoded wrongly.");

    AST_LINK_INT: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (!use_pclk_o && !pclk_edge) |=> (link_int_osc_o && !use_pclk_o))
        else $error("Internal oscillator not used without pixel clock.");

    AST_FREQ_HI: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (ce_i && osc_code == 2'h1 && payload_mode_i == RCS_PAY_10) |=> frame_freq_o == 8'hc8)
        else $error("Frame clock for code one wrong.");

    AST_BIST_LOAD: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (ce_i && bist_active_i && bist_osc_load_i) |=> osc_code == $past(bist_osc_sel_i))
        else $error("Select field not loaded from far end.");

    AST_STRAP_HELD: assert property (@(posedge core_clk_i) disable iff (rst_i)
        strap_valid_o |=> (strap_valid_o && $stable(osc_mode_o)))
        else $error("Strap mode changed after capture.");
endmodule

// ==== tb/rcs_partner_model.sv ====
// Far-side model: imager clocks and the deserializer's self-test controls.
// Assumes the bench supplies the core clock, payload mode and run enables.
`timescale 1ns/10ps

// ==========================================================================
// Partner model
// ==========================================================================
module rcs_partner_model (
    input wire logic core_clk_i, // Core clock.
    input wire rcs_pkg::rcs_payload_e payload_mode_i, // Payload mode.
    input wire logic osc_run_i, // External oscillator present.
    input wire logic pclk_run_i, // Imager pixel clock present.
    input wire logic self_test_enable_in_i, // Self-test enable pin.
    input wire logic remote_strap_line_zero_i, // Strap line zero.
    input wire logic remote_strap_line_one_i, // Strap line one.
    output logic osc_o, // External oscillator.
    output logic pclk_o, // Imager pixel clock.
    output logic bist_active_o, // Self test running.
    output logic bist_osc_load_o, // Select field load strobe.
    output logic [1:0] bist_osc_sel_o // Select code sent over the back channel.
);
    import rcs_pkg::*;

    logic pass_line; // Pass indicator as the far end shows it.
    logic [7:0] err_frames; // Errored-frame count, held between runs.

    // Initial levels, so the design never sees an unknown.
    initial begin
        pass_line = 1'b0;
        err_frames = 8'h00;
        osc_o = 1'b0;
        pclk_o = 1'b0;
        bist_active_o = 1'b0;
        bist_osc_load_o = 1'b0;
        bist_osc_sel_o = 2'h0;
    end

    // Oscillator, 480 ns period; it stands still while absent.
    always begin
        if (osc_run_i) begin
            #240 osc_o = ~osc_o;
        end else begin
            osc_o = 1'b0;
            @(posedge osc_run_i);
        end
    end

    // Pixel clock at twice or 1.5 times the oscillator rate by payload mode.
    always begin
        if (pclk_run_i) begin
            if (payload_mode_i == RCS_PAY_12H) begin
                #160 pclk_o = ~pclk_o;
            end else begin
                #120 pclk_o = ~pclk_o;
            end
        end else begin
            pclk_o = 1'b0;
            @(posedge pclk_run_i);
        end
    end

    // Self test follows the enable pin; the load is one pulse as a run starts,
    // and strap lines zero then one, in that order, pick the test clock.
    always @(posedge core_clk_i) begin
        bist_active_o <= self_test_enable_in_i;
        bist_osc_load_o <= self_test_enable_in_i && !bist_active_o;
        // The modelled link is error free: pass stays high through a run and
        // one cycle after it, and only a new run clears the count.
        pass_line <= self_test_enable_in_i || bist_active_o;
        if (self_test_enable_in_i && !bist_active_o) begin
            err_frames <= 8'h00;
        end
        case ({remote_strap_line_zero_i, remote_strap_line_one_i})
            2'h1: bist_osc_sel_o <= 2'h2;
            2'h2: bist_osc_sel_o <= 2'h3;
            default: bist_osc_sel_o <= 2'h0;
        endcase
    end
endmodule

// ==== tb/rcs_refclk_ctrl_tb_top.sv ====
// Self-checking bench for the reference-clock select block.
// Assumes the partner model drives clocks and self-test controls.
`timescale 1ns/10ps

// ==========================================================================
// Bench top
// ==========================================================================
module rcs_refclk_ctrl_tb_top;
    import rcs_pkg::*;
    logic clk, rst, ce, strap, osc, pclk, bact, bld, osc_run, pclk_run, bist_en, sl0, sl1;
    logic wr, rd, p_osc, p_div;
    logic [1:0] bsel;
    logic [3:0] gpo, gout, goe;
    logic [7:0] addr, wdata, freq;
    rcs_payload_e pay;
    rcs_byte_t rdata;
    logic osc_mode, strap_ok, use_pclk, int_osc;
    int mismatches, tests_run, n_osc, n_div;
    // Frame clock per payload mode (rows) and select code (columns).
    logic [7:0] ftab [3][4] = '{'{8'h64, 8'hc8, 8'h64, 8'h32},
        '{8'h4b, 8'h96, 8'h4b, 8'h00}, '{8'h32, 8'h64, 8'h32, 8'h00}};
    rcs_payload_e pmodes [3] = '{RCS_PAY_10, RCS_PAY_12H, RCS_PAY_12L};

    rcs_refclk_ctrl rcs_refclk_ctrl_inst (.core_clk_i(clk), .rst_i(rst), .ce_i(ce),
        .mode_strap_i(strap), .pclk_i(pclk), .gen_out_three_i(osc), .payload_mode_i(pay),
        .remote_gpo_i(gpo), .bist_active_i(bact), .bist_osc_load_i(bld),
        .bist_osc_sel_i(bsel), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .gen_out_o(gout), .gen_out_oe_o(goe),
        .osc_mode_o(osc_mode), .strap_valid_o(strap_ok), .use_pclk_o(use_pclk),
        .link_int_osc_o(int_osc), .frame_freq_o(freq));
    rcs_partner_model rcs_partner_model_inst (.core_clk_i(clk), .payload_mode_i(pay),
        .osc_run_i(osc_run), .pclk_run_i(pclk_run), .self_test_enable_in_i(bist_en),
        .remote_strap_line_zero_i(sl0), .remote_strap_line_one_i(sl1), .osc_o(osc),
        .pclk_o(pclk), .bist_active_o(bact), .bist_osc_load_o(bld), .bist_osc_sel_o(bsel));

    // Core clock, 40 ns period.
    initial clk = 1'b0;
    always #20 clk = ~clk;

    // Compares one value and reports a mismatch at once.
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Waits a number of falling edges.
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // One-cycle register write, launched at a falling edge.
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask

    // One-cycle register read; data is taken a cycle later, where it holds.
    task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        @(negedge clk);
        check("reg_rdata", exp, rdata);
    endtask

    // Holds reset for 2 cycles, then lets the strap settle.
    task automatic do_reset();
        rst = 1'b1;
        wait_cyc(2);
        rst = 1'b0;
        wait_cyc(8);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Watchdog: the tests need about 17 us.
    initial begin
        #400000;
        mismatches++;
        complete_run();
    end

    // Main sequence.
    initial begin
        rst = 1'b1; ce = 1'b1; strap = 1'b0; pay = RCS_PAY_10; gpo = 4'h0; addr = 8'h00;
        wr = 1'b0; rd = 1'b0; wdata = 8'h00; osc_run = 0; pclk_run = 0; bist_en = 0;
        sl0 = 1'b0; sl1 = 1'b0; mismatches = 0; tests_run = 0;
        do_reset();
        // Oscillator mode: strap held, divided clock, lines two and three claimed.
        check("strap_ok", 8'h1, 8'(strap_ok));
        check("osc_mode", 8'h1, 8'(osc_mode));
        strap = 1'b1;
        wait_cyc(8);
        check("osc_mode_held", 8'h1, 8'(osc_mode));
        gpo = 4'hf;
        osc_run = 1'b1;
        n_osc = 0; n_div = 0; p_osc = 1'b0; p_div = gout[2];
        repeat (260) begin
            @(negedge clk);
            n_osc += int'(osc && !p_osc);
            n_div += int'(gout[2] && !p_div);
            p_osc = osc;
            p_div = gout[2];
        end
        check("div_ratio", 8'h1, 8'(n_div * 2 >= n_osc - 1 && n_div * 2 <= n_osc + 1));
        check("osc_count", 8'd22, 8'(n_osc));
        check("gen_oe", 8'h4, 8'({4'h0, goe} & 8'hc));
        check("gen_three", 8'h0, 8'(gout[3]));
        osc_run = 1'b0;
        $display("Test oscillator mode done");
        // Pixel clock mode: all four lines follow the far end.
        do_reset();
        check("pclk_mode", 8'h0, 8'(osc_mode));
        check("int_osc", 8'h1, 8'({use_pclk, int_osc}));
        gpo = 4'ha;
        wait_cyc(3);
        check("gen_out", 8'h5a, {goe ^ 4'ha, gout});
        gpo = 4'h5;
        wait_cyc(3);
        check("gen_out", 8'h05, {goe ^ 4'hf, gout});
        // Registers: reset values, unmapped place.
        reg_read(8'h03, 8'h00);
        reg_read(8'h14, 8'h00);
        reg_write(8'h55, 8'hff);
        reg_read(8'h55, 8'h00);
        // Clock enable low: a write is ignored while the block is frozen.
        ce = 1'b0;
        reg_write(8'h03, 8'h02);
        ce = 1'b1;
        reg_read(8'h03, 8'h00);
        // Source switching on pixel clock arrival and loss, and the block bit.
        pclk_run = 1'b1;
        wait_cyc(12);
        check("use_pclk", 8'h2, 8'({use_pclk, int_osc}));
        pclk_run = 1'b0;
        wait_cyc(20);
        check("use_pclk_lost", 8'h1, 8'({use_pclk, int_osc}));
        reg_write(8'h03, 8'h02);
        reg_read(8'h03, 8'h02);
        pclk_run = 1'b1;
        wait_cyc(12);
        check("use_pclk_blk", 8'h1, 8'({use_pclk, int_osc}));
        pclk_run = 1'b0;
        reg_write(8'h03, 8'h00);
        wait_cyc(20);
        $display("Test pixel clock mode done");
        // Frame clock for every code in every payload mode.
        for (int m = 0; m < 3; m++) begin
            pay = pmodes[m];
            for (int c = 0; c < 4; c++) begin
                reg_write(8'h14, 8'(c << 1));
                reg_read(8'h14, 8'(c << 1));
                check("frame_freq", ftab[m][c], freq);
            end
        end
        $display("Test frame clock done");
        // Self test: field loaded from the far end, local write kept out.
        pay = RCS_PAY_10;
        for (int s = 1; s < 3; s++) begin
            {sl0, sl1} = 2'(s);
            bist_en = 1'b1;
            wait_cyc(4);
            check("bist_freq", s == 1 ? 8'h64 : 8'h32, freq);
            reg_write(8'h14, 8'h02);
            wait_cyc(2);
            check("bist_keep", s == 1 ? 8'h64 : 8'h32, freq);
            bist_en = 1'b0;
            wait_cyc(3);
        end
        reg_write(8'h14, 8'h02);
        wait_cyc(2);
        check("after_bist", 8'hc8, freq);
        $display("Test self test done");
        complete_run();
    end
endmodule
